// File: core/rtc_core.sv
// How it works
// - Calendar valid through 2099 with automatic February 29 in leap years.
// - Hour counter runs 00 to 23 only, no AM/PM form.
// - Short months roll into next month instead of reaching invalid dates.
// - After total power loss time stays still until a time register write.
// - Sub-second counter runs after total loss but carries nothing until written.
// - Crystal time base drives sub-second through year counters.
// - Frequency/logic pin chooses 512Hz or static level from two control bits.
// - Frequency/logic pin is open drain: pull low or release only.
// - Bus access is ignored while running from backup supply.
// - Timekeeping and the output pin keep working in backup mode.
// - Total power fail flag in status register set after powering up from loss.
// - Normal switching to backup needs main below backup and below trip.
// - Return to main when above backup or above trip plus hysteresis.
// - Low-power switching bit drops trip monitoring, switches on backup compare only.
// - Sealed device draws no backup current until main supply is applied.
// - Writing one to seal re-arm bit returns device to sealed state.
// - Digital trim shifts counting rate between -63.0696ppm and +126.139ppm.
//
// Design decisions made here: the placing of the registers and register access over Wishbone.
module rtc_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	output wire logic [31:0] dat_o,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output wire logic        ack_o,
	input  wire logic        xtal_i,
	input  wire logic        main_below_backup_i,
	input  wire logic        main_below_trip_i,
	input  wire logic        main_above_backup_i,
	input  wire logic        main_above_trip_i,
	output wire logic        freq_or_logic_out_pin_o,
	output wire logic        freq_or_logic_out_pin_oe_o,
	output wire logic        backup_mode_o,
	output wire logic        sealed_o,
	output wire logic        irq_o
);

	typedef struct packed {
		logic                     xs1;
		logic                     xs2;
		logic                     xs3;
		logic [3:0]               cs1;
		logic [3:0]               cs2;
		logic [16:0]              acc;
		logic [7:0]               hund;
		logic [5:0]               div;
		logic [18:0]              win;
		logic [5:0]               trim_left;
		logic                     trim_pos;
		rtc_pkg::pwr_state_t      pwr;
		logic                     running;
		logic                     fail;
		logic [7:0]               ctrl;
		logic                     lpm;
		logic [rtc_pkg::IRQ_W-1:0] ist;
		logic [rtc_pkg::IRQ_W-1:0] imask;
		logic                     ack;
		logic [31:0]              dat;
	} core_state_t;

	core_state_t s;
	core_state_t next_s;

	cal_if cal_bus ();

	rtc_calendar calendar (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cal   (cal_bus.cal)
	);

	logic        sec_tick;
	logic        cal_wr;
	logic [2:0]  cal_idx;
	logic [7:0]  cal_data;

	assign cal_bus.sec_tick = sec_tick;
	assign cal_bus.wr       = cal_wr;
	assign cal_bus.wr_idx   = cal_idx;
	assign cal_bus.wr_data  = cal_data;

	function automatic logic [5:0] trim_steps(input logic [7:0] ctrl);
		// Fast side counts double so the range spans -31..+62 steps of one tick per window
		if (ctrl[rtc_pkg::TRIM_SIGN_BIT]) begin
			trim_steps = {ctrl[4:0], 1'b0};
		end else begin
			trim_steps = {1'b0, ctrl[4:0]};
		end
	endfunction : trim_steps

	always_comb begin
		logic                      xedge;
		logic                      powered;
		logic                      bus_on;
		logic                      go_backup;
		logic                      go_main;
		logic                      req;
		logic                      wr;
		logic [5:0]                idx;
		logic [16:0]               step;
		logic [16:0]               sum;
		logic [rtc_pkg::IRQ_W-1:0] ev;
		logic [7:0]                rd;
		xedge     = 1'b0;
		powered   = 1'b0;
		bus_on    = 1'b0;
		go_backup = 1'b0;
		go_main   = 1'b0;
		req       = 1'b0;
		wr        = 1'b0;
		idx       = 6'h00;
		step      = rtc_pkg::ACC_STEP;
		sum       = 17'h00000;
		ev        = '0;
		rd        = 8'h00;
		sec_tick  = 1'b0;
		cal_wr    = 1'b0;
		cal_idx   = 3'h0;
		cal_data  = 8'h00;
		next_s    = s;

		// Crystal and comparators come from outside this clock: two flops first
		next_s.xs1 = xtal_i;
		next_s.xs2 = s.xs1;
		next_s.xs3 = s.xs2;
		next_s.cs1 = {main_above_trip_i, main_above_backup_i, main_below_trip_i,
		              main_below_backup_i};
		next_s.cs2 = s.cs1;

		xedge   = s.xs2 & ~s.xs3;
		powered = (s.pwr != rtc_pkg::PWR_SEAL_OFF);
		bus_on  = (s.pwr == rtc_pkg::PWR_MAIN) || (s.pwr == rtc_pkg::PWR_SEAL_ARMED);

		// Time base keeps running in backup mode, only a sealed-off device stops
		if (xedge && powered) begin
			next_s.div = s.div + 6'h01;
			if (s.trim_left != 6'h00) begin
				next_s.trim_left = s.trim_left - 6'h01;
				step = s.trim_pos ? rtc_pkg::ACC_STEP_FAST : rtc_pkg::ACC_STEP_NONE;
			end
			if (s.win == rtc_pkg::TRIM_WINDOW_TICKS - 19'h00001) begin
				next_s.win       = 19'h00000;
				next_s.trim_left = trim_steps(s.ctrl);
				next_s.trim_pos  = s.ctrl[rtc_pkg::TRIM_SIGN_BIT];
			end else begin
				next_s.win = s.win + 19'h00001;
			end
			// Fractional accumulator: 100 hundredths per 32768 crystal ticks
			sum = s.acc + step;
			if (sum >= rtc_pkg::XTAL_MOD) begin
				next_s.acc = sum - rtc_pkg::XTAL_MOD;
				if (s.hund == rtc_pkg::HUND_MAX) begin
					next_s.hund = 8'h00;
					sec_tick    = s.running;
				end else begin
					next_s.hund = rtc_pkg::bcd_inc(s.hund);
				end
			end else begin
				next_s.acc = sum;
			end
		end

		// Supply switchover
		go_backup = s.cs2[rtc_pkg::CMP_BELOW_BACKUP] &&
		            (s.lpm || s.cs2[rtc_pkg::CMP_BELOW_TRIP]);
		go_main   = s.cs2[rtc_pkg::CMP_ABOVE_BACKUP] ||
		            (!s.lpm && s.cs2[rtc_pkg::CMP_ABOVE_TRIP]);
		case (s.pwr)
			rtc_pkg::PWR_MAIN: begin
				if (go_backup) begin
					next_s.pwr                  = rtc_pkg::PWR_BACKUP;
					ev[rtc_pkg::IRQ_TO_BACKUP] = 1'b1;
				end
			end
			rtc_pkg::PWR_BACKUP: begin
				if (go_main) begin
					next_s.pwr                = rtc_pkg::PWR_MAIN;
					ev[rtc_pkg::IRQ_TO_MAIN] = 1'b1;
				end
			end
			rtc_pkg::PWR_SEAL_ARMED: begin
				if (go_backup) begin
					next_s.pwr = rtc_pkg::PWR_SEAL_OFF;
				end
			end
			rtc_pkg::PWR_SEAL_OFF: begin
				if (go_main) begin
					next_s.pwr                = rtc_pkg::PWR_MAIN;
					ev[rtc_pkg::IRQ_TO_MAIN] = 1'b1;
				end
			end
			default: begin
				next_s.pwr = rtc_pkg::PWR_MAIN;
			end
		endcase
		ev[rtc_pkg::IRQ_SECOND] = sec_tick;

		// Wishbone slave: one-cycle ack, registered read data
		req        = cyc_i && stb_i && !s.ack;
		idx        = adr_i[7:2];
		next_s.ack = req;
		wr         = req && we_i && sel_i[0] && bus_on;

		if (idx <= rtc_pkg::IDX_YEAR) begin
			rd = cal_bus.time_bcd[idx[2:0]];
		end else begin
			case (idx)
				rtc_pkg::IDX_CTRL:     rd = s.ctrl;
				rtc_pkg::IDX_LPM:      rd = {2'b00, s.lpm, 5'h00};
				rtc_pkg::IDX_STAT: begin
					rd = 8'h00;
					rd[rtc_pkg::STAT_SEAL_BIT]   = (s.pwr == rtc_pkg::PWR_SEAL_ARMED);
					rd[rtc_pkg::STAT_BACKUP_BIT] = (s.pwr == rtc_pkg::PWR_BACKUP);
					rd[rtc_pkg::STAT_FAIL_BIT]   = s.fail;
				end
				rtc_pkg::IDX_SUBSEC:   rd = s.hund;
				rtc_pkg::IDX_IRQ_STAT: rd = {5'h00, s.ist};
				rtc_pkg::IDX_IRQ_MASK: rd = {5'h00, s.imask};
				default:               rd = 8'h00;
			endcase
		end
		if (req) begin
			next_s.dat = bus_on ? {24'h000000, rd} : 32'h00000000;
		end

		if (wr) begin
			if (idx <= rtc_pkg::IDX_YEAR) begin
				cal_wr         = 1'b1;
				cal_idx        = idx[2:0];
				cal_data       = dat_i[7:0];
				next_s.running = 1'b1;
				next_s.fail    = 1'b0;
			end else begin
				case (idx)
					rtc_pkg::IDX_CTRL: next_s.ctrl = dat_i[7:0];
					rtc_pkg::IDX_LPM:  next_s.lpm  = dat_i[rtc_pkg::LPM_BIT];
					rtc_pkg::IDX_STAT: begin
						// Re-arm only while on main; a switchover in progress takes priority
						if (dat_i[rtc_pkg::STAT_SEAL_BIT] && s.pwr == rtc_pkg::PWR_MAIN &&
						    !go_backup) begin
							next_s.pwr = rtc_pkg::PWR_SEAL_ARMED;
						end
					end
					rtc_pkg::IDX_IRQ_STAT: next_s.ist   = s.ist & ~dat_i[rtc_pkg::IRQ_W-1:0];
					rtc_pkg::IDX_IRQ_MASK: next_s.imask = dat_i[rtc_pkg::IRQ_W-1:0];
					default: begin
					end
				endcase
			end
		end
		// An event in the clearing cycle still sets its bit
		next_s.ist = next_s.ist | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s           <= '0;
			s.pwr       <= rtc_pkg::PWR_MAIN;
			s.ctrl      <= rtc_pkg::CTRL_RESET;
			s.fail      <= 1'b1;
			s.running   <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	logic pin_level;
	assign pin_level = s.ctrl[rtc_pkg::CTRL_FREQ_BIT] ? s.div[rtc_pkg::FREQ_DIV_BITS-1] :
	                   s.ctrl[rtc_pkg::CTRL_OUT_BIT];

	// Only ever pulls low; a high level is the external pull-up
	assign freq_or_logic_out_pin_o    = 1'b0;
	assign freq_or_logic_out_pin_oe_o = (s.pwr != rtc_pkg::PWR_SEAL_OFF) && !pin_level;
	assign backup_mode_o              = (s.pwr == rtc_pkg::PWR_BACKUP);
	assign sealed_o                   = (s.pwr == rtc_pkg::PWR_SEAL_ARMED) ||
	                                    (s.pwr == rtc_pkg::PWR_SEAL_OFF);
	assign irq_o                      = |(s.ist & s.imask);
	assign ack_o                      = s.ack;
	assign dat_o                      = s.dat;

endmodule : rtc_core

// File: core/rtc_pkg.sv
package rtc_pkg;

	// Crystal time base and hundredths generation
	localparam int          XTAL_HZ           = 32768;
	localparam int          TRIM_WINDOW_SEC   = 15;
	localparam logic [18:0] TRIM_WINDOW_TICKS = 19'(XTAL_HZ * TRIM_WINDOW_SEC);
	localparam logic [16:0] XTAL_MOD          = 17'h08000;
	localparam logic [16:0] ACC_STEP          = 17'h00064;
	localparam logic [16:0] ACC_STEP_FAST     = 17'h000C8;
	localparam logic [16:0] ACC_STEP_NONE     = 17'h00000;
	localparam int          FREQ_DIV_BITS     = 6;
	localparam logic [7:0]  HUND_MAX          = 8'h99;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_SEC      = 6'h00;
	localparam logic [5:0] IDX_YEAR     = 6'h06;
	localparam logic [5:0] IDX_CTRL     = 6'h07;
	localparam logic [5:0] IDX_LPM      = 6'h08;
	localparam logic [5:0] IDX_STAT     = 6'h0B;
	localparam logic [5:0] IDX_SUBSEC   = 6'h1F;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

	// Field positions
	localparam int CTRL_OUT_BIT    = 7;
	localparam int CTRL_FREQ_BIT   = 6;
	localparam int TRIM_SIGN_BIT   = 5;
	localparam int LPM_BIT         = 5;
	localparam int STAT_SEAL_BIT   = 5;
	localparam int STAT_BACKUP_BIT = 1;
	localparam int STAT_FAIL_BIT   = 0;
	localparam int IRQ_TO_BACKUP   = 0;
	localparam int IRQ_TO_MAIN     = 1;
	localparam int IRQ_SECOND      = 2;
	localparam int IRQ_W           = 3;

	localparam logic [7:0] CTRL_RESET = 8'h80;

	// Calendar fields, index 0 seconds .. 6 year
	localparam logic [2:0] F_SEC   = 3'h0;
	localparam logic [2:0] F_MIN   = 3'h1;
	localparam logic [2:0] F_HOUR  = 3'h2;
	localparam logic [2:0] F_DOW   = 3'h3;
	localparam logic [2:0] F_DATE  = 3'h4;
	localparam logic [2:0] F_MONTH = 3'h5;
	localparam logic [2:0] F_YEAR  = 3'h6;

	localparam logic [6:0][7:0] FIELD_MASK = {8'hFF, 8'h1F, 8'h3F, 8'h07, 8'h3F, 8'h7F, 8'h7F};
	localparam logic [6:0][7:0] TIME_RESET = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};

	localparam logic [7:0] SEC_MAX   = 8'h59;
	localparam logic [7:0] HOUR_MAX  = 8'h23;
	localparam logic [7:0] DOW_MAX   = 8'h07;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [7:0] FIRST_ONE = 8'h01;
	localparam logic [7:0] FEB       = 8'h02;
	localparam logic [7:0] APR       = 8'h04;
	localparam logic [7:0] JUN       = 8'h06;
	localparam logic [7:0] SEP       = 8'h09;
	localparam logic [7:0] NOV       = 8'h11;
	localparam logic [7:0] DAYS_28   = 8'h28;
	localparam logic [7:0] DAYS_29   = 8'h29;
	localparam logic [7:0] DAYS_30   = 8'h30;
	localparam logic [7:0] DAYS_31   = 8'h31;

	// Synchronised comparator inputs
	localparam int CMP_BELOW_BACKUP = 0;
	localparam int CMP_BELOW_TRIP   = 1;
	localparam int CMP_ABOVE_BACKUP = 2;
	localparam int CMP_ABOVE_TRIP   = 3;

	typedef enum logic [1:0] {
		PWR_MAIN       = 2'b00,
		PWR_BACKUP     = 2'b01,
		PWR_SEAL_ARMED = 2'b10,
		PWR_SEAL_OFF   = 2'b11
	} pwr_state_t;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

endpackage : rtc_pkg

// File: core/cal_if.sv
interface cal_if;
	logic            sec_tick;
	logic            wr;
	logic [2:0]      wr_idx;
	logic [7:0]      wr_data;
	logic [6:0][7:0] time_bcd;

	modport ctl (output sec_tick, output wr, output wr_idx, output wr_data, input time_bcd);
	modport cal (input sec_tick, input wr, input wr_idx, input wr_data, output time_bcd);
endinterface : cal_if

// File: core/rtc_calendar.sv
module rtc_calendar (
	input wire logic clk_i,
	input wire logic rst_i,
	cal_if.cal       cal
);

	typedef struct packed {
		logic [6:0][7:0] t;
	} cal_state_t;

	cal_state_t s;
	cal_state_t next_s;

	function automatic logic [7:0] last_day(input logic [7:0] month, input logic [7:0] year);
		logic [3:0] rem;
		rem = {2'b00, year[4], 1'b0} + year[3:0];
		if (month == rtc_pkg::FEB) begin
			// Tens parity plus ones decides divisibility by four; 2000 counts as leap
			last_day = (rem[1:0] == 2'b00) ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
		end else if (month == rtc_pkg::APR || month == rtc_pkg::JUN ||
		             month == rtc_pkg::SEP || month == rtc_pkg::NOV) begin
			last_day = rtc_pkg::DAYS_30;
		end else begin
			last_day = rtc_pkg::DAYS_31;
		end
	endfunction : last_day

	always_comb begin
		next_s = s;
		if (cal.wr) begin
			next_s.t[cal.wr_idx] = cal.wr_data & rtc_pkg::FIELD_MASK[cal.wr_idx];
		end else if (cal.sec_tick) begin
			if (s.t[rtc_pkg::F_SEC] != rtc_pkg::SEC_MAX) begin
				next_s.t[rtc_pkg::F_SEC] = rtc_pkg::bcd_inc(s.t[rtc_pkg::F_SEC]);
			end else begin
				next_s.t[rtc_pkg::F_SEC] = 8'h00;
				if (s.t[rtc_pkg::F_MIN] != rtc_pkg::SEC_MAX) begin
					next_s.t[rtc_pkg::F_MIN] = rtc_pkg::bcd_inc(s.t[rtc_pkg::F_MIN]);
				end else begin
					next_s.t[rtc_pkg::F_MIN] = 8'h00;
					if (s.t[rtc_pkg::F_HOUR] != rtc_pkg::HOUR_MAX) begin
						next_s.t[rtc_pkg::F_HOUR] = rtc_pkg::bcd_inc(s.t[rtc_pkg::F_HOUR]);
					end else begin
						next_s.t[rtc_pkg::F_HOUR] = 8'h00;
						if (s.t[rtc_pkg::F_DOW] >= rtc_pkg::DOW_MAX) begin
							next_s.t[rtc_pkg::F_DOW] = rtc_pkg::FIRST_ONE;
						end else begin
							next_s.t[rtc_pkg::F_DOW] = rtc_pkg::bcd_inc(s.t[rtc_pkg::F_DOW]);
						end
						if (s.t[rtc_pkg::F_DATE] < last_day(s.t[rtc_pkg::F_MONTH],
						                                     s.t[rtc_pkg::F_YEAR])) begin
							next_s.t[rtc_pkg::F_DATE] = rtc_pkg::bcd_inc(s.t[rtc_pkg::F_DATE]);
						end else begin
							next_s.t[rtc_pkg::F_DATE] = rtc_pkg::FIRST_ONE;
							if (s.t[rtc_pkg::F_MONTH] >= rtc_pkg::MONTH_MAX) begin
								next_s.t[rtc_pkg::F_MONTH] = rtc_pkg::FIRST_ONE;
								// Two-digit year wraps after 99; 2100 not handled
								if (s.t[rtc_pkg::F_YEAR] == rtc_pkg::YEAR_MAX) begin
									next_s.t[rtc_pkg::F_YEAR] = 8'h00;
								end else begin
									next_s.t[rtc_pkg::F_YEAR] =
										rtc_pkg::bcd_inc(s.t[rtc_pkg::F_YEAR]);
								end
							end else begin
								next_s.t[rtc_pkg::F_MONTH] = rtc_pkg::bcd_inc(s.t[rtc_pkg::F_MONTH]);
							end
						end
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s.t <= rtc_pkg::TIME_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign cal.time_bcd = s.t;

endmodule : rtc_calendar

// File: tb/rtc_env.sv
module rtc_env (
	input  wire logic [15:0] vdd_mv_i,
	input  wire logic [15:0] vbat_mv_i,
	output var  logic        xtal_o,
	output var  logic        below_backup_o,
	output var  logic        below_trip_o,
	output var  logic        above_backup_o,
	output var  logic        above_trip_o
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] TRIP_MV  = 16'h0A28;
	localparam logic [15:0] BAT_HYS  = 16'h0032;
	localparam logic [15:0] TRIP_HYS = 16'h001E;
	// Odd phase keeps crystal edges away from clock edges
	initial begin
		xtal_o = 1'b0;
		#130;
		forever #200 xtal_o = ~xtal_o;
	end
	always_comb begin
		below_backup_o = vdd_mv_i < vbat_mv_i - BAT_HYS;
		below_trip_o   = vdd_mv_i < TRIP_MV;
		above_backup_o = vdd_mv_i > vbat_mv_i + BAT_HYS;
		above_trip_o   = vdd_mv_i > TRIP_MV + TRIP_HYS;
	end
endmodule : rtc_env

// File: tb/rtc_core_properties.sv
module rtc_core_properties (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic [7:0]  adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        we_i,
	input wire logic [3:0]  sel_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic        xtal_i,
	input wire logic        main_below_backup_i,
	input wire logic        main_below_trip_i,
	input wire logic        main_above_backup_i,
	input wire logic        main_above_trip_i,
	input wire logic        freq_or_logic_out_pin_o,
	input wire logic        freq_or_logic_out_pin_oe_o,
	input wire logic        backup_mode_o,
	input wire logic        sealed_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       lp;
	logic       wr_ok;
	logic [5:0] idx;
	assign idx = adr_i[7:2];
	assign wr_ok = cyc_i && stb_i && we_i && ack_o && sel_i[0] && !backup_mode_o;
	// Shadow of the switching mode, since the register is not at the ports
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lp <= 1'b0;
		end else if (wr_ok && idx == rtc_pkg::IDX_LPM) begin
			lp <= dat_i[rtc_pkg::LPM_BIT];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged next cycle");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("acknowledge longer than one cycle");
	a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
		else $error("acknowledge without request");
	a_read_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_pin_open_drain: assert property (freq_or_logic_out_pin_o == 1'b0)
		else $error("output pin driven high");
	a_to_backup: assert property ($rose(backup_mode_o) |->
		$past(main_below_backup_i, 2) && (lp || $past(main_below_trip_i, 2)))
		else $error("backup entered without both conditions");
	a_to_main: assert property ($fell(backup_mode_o) |->
		$past(main_above_backup_i, 2) || $past(main_above_trip_i, 2))
		else $error("main resumed without condition");
	a_backup_bus_dead: assert property (
		$past(backup_mode_o) && backup_mode_o && ack_o && !we_i |-> dat_o == 32'h0)
		else $error("read answered in backup mode");
	a_sealed_no_draw: assert property (sealed_o |-> !backup_mode_o)
		else $error("backup drawn while sealed");
	a_seal_rearm: assert property (wr_ok && idx == rtc_pkg::IDX_STAT &&
		dat_i[rtc_pkg::STAT_SEAL_BIT] |-> sealed_o)
		else $error("seal request not taken");
	c_backup: cover property ($rose(backup_mode_o));
	c_sealed: cover property ($rose(sealed_o));
	c_irq: cover property ($rose(irq_o));
	c_write: cover property (ack_o && we_i);
endmodule : rtc_core_properties

bind rtc_core rtc_core_properties i_props (
	.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i),
	.sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .xtal_i(xtal_i),
	.main_below_backup_i(main_below_backup_i), .main_below_trip_i(main_below_trip_i),
	.main_above_backup_i(main_above_backup_i), .main_above_trip_i(main_above_trip_i),
	.freq_or_logic_out_pin_o(freq_or_logic_out_pin_o),
	.freq_or_logic_out_pin_oe_o(freq_or_logic_out_pin_oe_o),
	.backup_mode_o(backup_mode_o), .sealed_o(sealed_o), .irq_o(irq_o)
);

// File: tb/test_rtc_core.sv
module test_rtc_core;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic        we_i  = 1'b0;
	logic [3:0]  sel_i = 4'h0;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic [15:0] vdd   = 16'h0CE4;
	logic [15:0] vbat  = 16'h0BB8;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack_o, xtal, b_bk, b_tr, a_bk, a_tr, pin, oe, bkp, sealed, irq;
	wire         pin_level = oe ? pin : 1'b1;
	int          bad_count = 0;
	int          compares  = 0;

	always #25 clk_i = ~clk_i;

	rtc_env i_env (.vdd_mv_i(vdd), .vbat_mv_i(vbat), .xtal_o(xtal), .below_backup_o(b_bk),
		.below_trip_o(b_tr), .above_backup_o(a_bk), .above_trip_o(a_tr));

	rtc_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
		.we_i(we_i), .sel_i(sel_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .xtal_i(xtal),
		.main_below_backup_i(b_bk), .main_below_trip_i(b_tr), .main_above_backup_i(a_bk),
		.main_above_trip_i(a_tr), .freq_or_logic_out_pin_o(pin),
		.freq_or_logic_out_pin_oe_o(oe), .backup_mode_o(bkp), .sealed_o(sealed), .irq_o(irq));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		sel_i <= 4'h1;
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		check("ack", {31'h0, ack_o}, 32'h1);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask : bus

	task automatic rdchk(input string what, input logic [5:0] idx, input logic [7:0] exp);
		bus(1'b0, idx, 8'h00);
		check(what, rd, {24'h0, exp});
	endtask : rdchk

	task automatic sig(input string what, input logic seen, input logic exp);
		@(posedge clk_i);
		check(what, {31'h0, seen}, {31'h0, exp});
	endtask : sig

	// Comparators pass two sync stages; twelve cycles covers that with margin
	task automatic power(input logic [15:0] mv, input logic exp);
		@(posedge clk_i);
		vdd <= mv;
		repeat (12) @(posedge clk_i);
		check("backup mode", {31'h0, bkp}, {31'h0, exp});
	endtask : power

	task automatic t_reset;
		rdchk("status", rtc_pkg::IDX_STAT, 8'h01);
		rdchk("control", rtc_pkg::IDX_CTRL, rtc_pkg::CTRL_RESET);
		sig("pin idle", pin_level, 1'b1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_frozen;
		logic [31:0] first;
		bus(1'b0, rtc_pkg::IDX_SUBSEC, 8'h00);
		first = rd;
		repeat (3000) @(posedge clk_i);
		bus(1'b0, rtc_pkg::IDX_SUBSEC, 8'h00);
		check("subsec runs", {31'h0, rd !== first}, 32'h1);
		rdchk("sec frozen", rtc_pkg::IDX_SEC, 8'h00);
		bus(1'b1, 6'h15, 8'h55);
		rdchk("unmapped", 6'h15, 8'h00);
		rdchk("fail kept", rtc_pkg::IDX_STAT, 8'h01);
		bus(1'b1, rtc_pkg::IDX_SEC, 8'h30);
		rdchk("fail cleared", rtc_pkg::IDX_STAT, 8'h00);
		rdchk("sec written", rtc_pkg::IDX_SEC, 8'h30);
		$display("test frozen done");
	endtask : t_frozen

	task automatic t_freq;
		logic [7:0] modes [2] = '{8'h40, 8'h7F};
		int         r1;
		int         n;
		logic       last;
		foreach (modes[i]) begin
			bus(1'b1, rtc_pkg::IDX_CTRL, modes[i]);
			r1 = -1;
			n = 0;
			last = oe;
			while (n < 2000) begin
				@(posedge clk_i);
				n++;
				if (oe === 1'b1 && last === 1'b0) begin
					if (r1 >= 0) break;
					r1 = n;
				end
				last = oe;
			end
			check("pin period", 32'(n - r1), 32'd512);
		end
		bus(1'b1, rtc_pkg::IDX_CTRL, 8'h80);
		sig("pin released", pin_level, 1'b1);
		bus(1'b1, rtc_pkg::IDX_CTRL, 8'h00);
		sig("pin low", pin_level, 1'b0);
		$display("test freq done");
	endtask : t_freq

	task automatic t_power;
		bus(1'b1, rtc_pkg::IDX_IRQ_MASK, 8'h03);
		power(16'h0AF0, 1'b0);
		power(16'h0B54, 1'b0);
		power(16'h09C4, 1'b1);
		sig("irq raised", irq, 1'b1);
		sig("pin in backup", pin_level, 1'b0);
		rdchk("bus ignored", rtc_pkg::IDX_SEC, 8'h00);
		bus(1'b1, rtc_pkg::IDX_CTRL, 8'h80);
		power(16'h0A3C, 1'b1);
		power(16'h0A50, 1'b0);
		rdchk("ctrl kept", rtc_pkg::IDX_CTRL, 8'h00);
		rdchk("irq status", rtc_pkg::IDX_IRQ_STAT, 8'h03);
		bus(1'b1, rtc_pkg::IDX_IRQ_MASK, 8'h00);
		sig("irq masked", irq, 1'b0);
		bus(1'b1, rtc_pkg::IDX_IRQ_MASK, 8'h03);
		sig("irq unmasked", irq, 1'b1);
		bus(1'b1, rtc_pkg::IDX_IRQ_STAT, 8'h03);
		sig("irq cleared", irq, 1'b0);
		power(16'h0CE4, 1'b0);
		$display("test power done");
	endtask : t_power

	task automatic t_lowpower;
		bus(1'b1, rtc_pkg::IDX_LPM, 8'h20);
		power(16'h0B7C, 1'b1);
		power(16'h0BF4, 1'b0);
		bus(1'b1, rtc_pkg::IDX_LPM, 8'h00);
		power(16'h0CE4, 1'b0);
		$display("test lowpower done");
	endtask : t_lowpower

	task automatic t_seal;
		bus(1'b1, rtc_pkg::IDX_STAT, 8'h20);
		sig("sealed", sealed, 1'b1);
		power(16'h03E8, 1'b0);
		sig("still sealed", sealed, 1'b1);
		power(16'h0CE4, 1'b0);
		sig("unsealed", sealed, 1'b0);
		power(16'h09C4, 1'b1);
		power(16'h0CE4, 1'b0);
		$display("test seal done");
	endtask : t_seal

	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset;
		t_frozen;
		t_freq;
		t_power;
		t_lowpower;
		t_seal;
		finish_test;
	end

	// Tests need about 5000 cycles
	initial begin
		repeat (60000) @(posedge clk_i);
		bad_count++;
		finish_test;
	end
endmodule : test_rtc_core
